// ==== basc_top.sv ====
// basc_top: serial port, configuration/sleep control and conversion word timing
// assumes the host drives chip select, serial clock and data in; serial clock is a link clock
`timescale 1ns/1ns
module basc_top #(
  parameter int WORD_PERIOD = basc_pkg::WORD_PERIOD  // master clocks per output word
) (
  input  wire logic                 CLOCK,            // master clock
  input  wire logic                 RST_B,            // sync reset, active low
  input  wire logic                 SCLK,             // serial clock from host
  input  wire logic                 CS_N,             // chip select, active low
  input  wire logic                 SERIAL_IN_LINE,   // serial data in
  input  wire logic                 WIRING_MODE_SELECT, // low: 4/5 wire, high: 3 wire
  input  wire logic [19:0]          CONV_RESULT,      // modulator result
  input  wire logic                 OVERRANGE,        // input overrange
  input  wire logic                 CAL_BUSY,         // calibration in progress
  output logic                      SERIAL_OUT_LINE,  // serial data out value
  output logic                      SERIAL_OUT_OE,    // serial data out enable
  output logic                      DATA_READY_N,     // new word ready, active low
  output logic                      SLEEP,            // circuitry powered down
  output logic                      FILTER_RESET_BIT  // filter held in reset
);
  ////////////////////////////////////////////////////////////////////////////
  // reset crossing into the serial clock domain
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge SCLK) begin
    rst_s1_q <= RST_B;
    rst_s2_q <= rst_s1_q;
  end

  // chip select gating: in three-wire mode the port is always selected
  logic sel;
  assign sel = WIRING_MODE_SELECT | ~CS_N;

  // calibration select decode for the write path; readback lists the same selects in its own case
  function automatic logic basc_is_cal(input logic [3:0] code);
    basc_is_cal = (code >= basc_pkg::SEL_GAIN) && (code <= basc_pkg::SEL_NOFS);
  endfunction : basc_is_cal

  ////////////////////////////////////////////////////////////////////////////
  // serial port state, rising edge samples input
  basc_pkg::basc_port_t st_q, st_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [23:0] sh_q, sh_d;
  logic [3:0]  sel_q, sel_d;
  logic [23:0] cfg_q, cfg_d;
  logic [23:0] cal_q [2:5];
  logic [23:0] cal_d [2:5];
  logic        wtog_q, wtog_d;   // write-done toggle to core
  logic        rtog_q, rtog_d;   // conversion-read-done toggle to core
  logic [23:0] out_word;         // word snapshot from core, stable while read

  // next state of the serial port
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; sel_d = sel_q; cfg_d = cfg_q;
    wtog_d = wtog_q; rtog_d = rtog_q;
    for (int i = 2; i <= 5; i++) cal_d[i] = cal_q[i];
    if (!rst_s2_q) begin
      st_d = basc_pkg::BASC_CMD;
      cnt_d = '0;
      cfg_d = basc_pkg::CFG_RESET;
      for (int i = 2; i <= 5; i++) cal_d[i] = basc_pkg::CAL_RESET;
    end else if (sel) begin // line ignored unless selected
      unique case (st_q)
        basc_pkg::BASC_CMD: begin
          sh_d = {sh_q[22:0], SERIAL_IN_LINE};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'(basc_pkg::CMD_BITS - 1)) begin
            cnt_d = '0;
            sel_d = sh_d[3:0];
            st_d  = sh_d[basc_pkg::CMD_WR_POS] ? basc_pkg::BASC_WR : basc_pkg::BASC_RD;
          end
        end
        basc_pkg::BASC_WR: begin
          sh_d = {sh_q[22:0], SERIAL_IN_LINE};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'(basc_pkg::WORD_BITS - 1)) begin
            cnt_d = '0;
            st_d  = basc_pkg::BASC_CMD;
            wtog_d = ~wtog_q;
            if (sel_q == basc_pkg::SEL_CFG) cfg_d = sh_d;
            else if (basc_is_cal(sel_q)) cal_d[sel_q] = sh_d;
          end
        end
        basc_pkg::BASC_RD: begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'(basc_pkg::WORD_BITS - 1)) begin
            cnt_d = '0;
            st_d  = basc_pkg::BASC_CMD;
            if (sel_q == basc_pkg::SEL_CONV) rtog_d = ~rtog_q;
          end
        end
        default: st_d = basc_pkg::BASC_CMD;
      endcase
    end
  end

  // serial port registers
  always_ff @(posedge SCLK) begin
    st_q <= st_d; cnt_q <= cnt_d; sh_q <= sh_d; sel_q <= sel_d; cfg_q <= cfg_d;
    wtog_q <= wtog_d; rtog_q <= rtog_d;
    for (int i = 2; i <= 5; i++) cal_q[i] <= cal_d[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // output shifter on the falling edge, msb first
  logic [23:0] tx_q, tx_d;
  logic        txen_q, txen_d;
  logic [23:0] rd_src;
  // conversion, configuration or calibration source picked by the last command
  always_comb begin
    unique case (sel_q)
      basc_pkg::SEL_CONV: rd_src = out_word;
      basc_pkg::SEL_CFG:  rd_src = cfg_q;
      basc_pkg::SEL_GAIN, basc_pkg::SEL_DAC,
      basc_pkg::SEL_ROFS, basc_pkg::SEL_NOFS: rd_src = cal_q[sel_q];
      default:            rd_src = '0;
    endcase
  end
  // load at start of read, shift on each falling edge
  always_comb begin
    tx_d = tx_q; txen_d = 1'b0;
    if (rst_s2_q && sel && st_q == basc_pkg::BASC_RD) begin
      txen_d = 1'b1;
      tx_d = (cnt_q == '0) ? rd_src : {tx_q[22:0], 1'b0};
    end
  end
  always_ff @(negedge SCLK) begin
    tx_q <= tx_d;
    txen_q <= txen_d;
  end
  assign SERIAL_OUT_LINE = tx_q[23];
  // floats unless transmitting; three-wire mode keeps the line driven
  assign SERIAL_OUT_OE = WIRING_MODE_SELECT | (~CS_N & txen_q);

  ////////////////////////////////////////////////////////////////////////////
  // crossings into the master clock domain
  // toggles pass two flops; the third only detects the change
  logic w1_q, w2_q, w3_q, r1_q, r2_q, r3_q;
  always_ff @(posedge CLOCK) begin
    w1_q <= wtog_q; w2_q <= w1_q; w3_q <= w2_q;
    r1_q <= rtog_q; r2_q <= r1_q; r3_q <= r2_q;
  end
  logic wr_done, rd_done;
  assign wr_done = w2_q ^ w3_q; // filter resumes only after the 24th edge
  assign rd_done = r2_q ^ r3_q;

  // config bits taken only on a finished write, while the serial copy is still;
  // two loose synchronisers could split sleep and filter reset by a cycle
  basc_pkg::basc_cfg_t cfg_c, cfg_hold_q, cfg_hold_d;
  always_comb begin
    cfg_hold_d = cfg_hold_q;
    if (!RST_B) cfg_hold_d = '0;
    else if (wr_done) cfg_hold_d = basc_pkg::basc_cfg_t'({cfg_q[basc_pkg::CFG_FRST_POS],
                                                          cfg_q[basc_pkg::CFG_SLEEP_POS]});
  end
  always_ff @(posedge CLOCK) begin
    cfg_hold_q <= cfg_hold_d;
  end
  assign cfg_c = cfg_hold_q;

  ////////////////////////////////////////////////////////////////////////////
  // conversion timing and data ready
  logic [16:0] tim_q, tim_d;
  logic        halt_q, halt_d;
  logic        rdy_q, rdy_d;
  logic [23:0] word_q, word_d;
  // timer halted in sleep or filter reset, restarts after the write completes
  always_comb begin
    tim_d = tim_q; halt_d = halt_q; rdy_d = rdy_q; word_d = word_q;
    if (!RST_B) begin
      tim_d = '0; halt_d = 1'b0; rdy_d = 1'b1; word_d = '0;
    end else begin
      // follows the held config, so it clears only once the clearing write is done
      halt_d = cfg_hold_d.sleep | cfg_hold_d.frst;
      if (halt_q || cfg_c.sleep || cfg_c.frst) begin
        tim_d = '0;
        rdy_d = 1'b1;
      end else if (tim_q == 17'(WORD_PERIOD - 1)) begin
        tim_d = '0;
        word_d = {CONV_RESULT, {basc_pkg::FLAG_BITS{OVERRANGE}}};
        rdy_d = CAL_BUSY;
      end else begin
        tim_d = tim_q + 17'h00001;
        if (rd_done || CAL_BUSY) rdy_d = 1'b1;
        if (tim_q == 17'(WORD_PERIOD - 2)) rdy_d = 1'b1; // refresh window
      end
    end
  end
  always_ff @(posedge CLOCK) begin
    tim_q <= tim_d; halt_q <= halt_d; rdy_q <= rdy_d; word_q <= word_d;
  end
  assign out_word = word_q; // sampled by serial side only at read start
  assign DATA_READY_N = rdy_q;
  assign SLEEP = cfg_c.sleep;
  assign FILTER_RESET_BIT = cfg_c.frst;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_ready_period: assert property (@(posedge CLOCK) disable iff (!RST_B)
    $fell(rdy_q) |-> tim_q == '0) else $error("data ready fell off period");
  a_sleep_ready: assert property (@(posedge CLOCK) disable iff (!RST_B)
    cfg_c.sleep |=> rdy_q) else $error("data ready low while asleep");
  a_frst_halt: assert property (@(posedge CLOCK) disable iff (!RST_B)
    cfg_c.frst |=> tim_q == '0) else $error("timer ran in filter reset");
  a_float_cs: assert property (@(posedge CLOCK)
    (CS_N && !WIRING_MODE_SELECT) |-> !SERIAL_OUT_OE) else $error("output driven while deselected");
  a_reset_cfg: assert property (@(posedge SCLK)
    !rst_s2_q |=> cfg_q == basc_pkg::CFG_RESET && st_q == basc_pkg::BASC_CMD) else $error("reset state wrong");

  ////////////////////////////////////////////////////////////////////////////
  // core domain checks: timer and data ready stand still while asleep
  sequence s_asleep;
    cfg_c.sleep;
  endsequence
  a_sleep_timer: assert property (@(posedge CLOCK) disable iff (!RST_B)
    s_asleep |=> tim_q == '0 && rdy_q) else $error("timer ran while asleep");

  // a fresh word carries the result and copies of the overrange flag
  sequence s_word_end;
    !halt_q && !cfg_c.sleep && !cfg_c.frst && tim_q == 17'(WORD_PERIOD - 1);
  endsequence
  a_flag_fill: assert property (@(posedge CLOCK) disable iff (!RST_B)
    s_word_end |=> word_q == {$past(CONV_RESULT), {basc_pkg::FLAG_BITS{$past(OVERRANGE)}}})
    else $error("flag bits do not follow overrange");

  // one cycle before the period ends the output port is refreshed
  a_ready_refresh: assert property (@(posedge CLOCK) disable iff (!RST_B)
    tim_q == 17'(WORD_PERIOD - 2) |=> rdy_q) else $error("data ready low during refresh");

  // ready returns high once a conversion read has landed
  a_read_done: assert property (@(posedge CLOCK) disable iff (!RST_B)
    rd_done && tim_q != 17'(WORD_PERIOD - 1) |=> rdy_q) else $error("data ready low after read");

  // a calibration in progress keeps ready high
  a_cal_ready: assert property (@(posedge CLOCK) disable iff (!RST_B)
    CAL_BUSY |=> rdy_q) else $error("data ready low during calibration");

  // the timer resumes only on a write that leaves sleep and filter reset both clear
  a_resume_gate: assert property (@(posedge CLOCK) disable iff (!RST_B)
    $fell(halt_q) && $past(RST_B) |-> $past(wr_done)) else $error("filter resumed without a write");

  // the timer never passes the end of a word period
  a_period_bound: assert property (@(posedge CLOCK) disable iff (!RST_B)
    tim_q <= 17'(WORD_PERIOD - 1)) else $error("word timer out of range");

  // reset leaves the core awake, idle and with ready high
  a_reset_ready: assert property (@(posedge CLOCK)
    !RST_B |=> rdy_q && tim_q == '0 && word_q == '0 && cfg_c == '0) else $error("core reset state wrong");

  // three-wire mode keeps the output line driven
  a_oe_3wire: assert property (@(posedge CLOCK)
    WIRING_MODE_SELECT |-> SERIAL_OUT_OE) else $error("three wire output not driven");

  ////////////////////////////////////////////////////////////////////////////
  // link domain checks: a deselected port holds its state
  sequence s_deselected;
    rst_s2_q && !sel;
  endsequence
  a_idle_hold: assert property (@(posedge SCLK)
    s_deselected |=> $stable(st_q) && $stable(cnt_q) && $stable(cfg_q))
    else $error("port moved while deselected");

  // the bit counter never passes the last bit of a word
  a_count_range: assert property (@(posedge SCLK)
    rst_s2_q |-> cnt_q <= 5'(basc_pkg::WORD_BITS - 1)) else $error("bit counter out of range");

  // every falling edge of a read after the load edge moves the word one place towards the msb
  sequence s_tx_shift;
    rst_s2_q && sel && st_q == basc_pkg::BASC_RD && cnt_q != '0;
  endsequence
  a_tx_shift: assert property (@(negedge SCLK)
    s_tx_shift |=> tx_q == {$past(tx_q[22:0]), 1'b0}) else $error("output word not shifted msb first");

  // a finished configuration write stores the last bits seen on the input line
  sequence s_cfg_write;
    rst_s2_q && sel && st_q == basc_pkg::BASC_WR &&
    cnt_q == 5'(basc_pkg::WORD_BITS - 1) && sel_q == basc_pkg::SEL_CFG;
  endsequence
  a_cfg_store: assert property (@(posedge SCLK)
    s_cfg_write |=> cfg_q == {$past(sh_q[22:0]), $past(SERIAL_IN_LINE)}) else $error("config write lost");

  // reset returns every calibration register to its initial value
  a_cal_reset: assert property (@(posedge SCLK)
    !rst_s2_q |=> cal_q[2] == basc_pkg::CAL_RESET && cal_q[3] == basc_pkg::CAL_RESET &&
                  cal_q[4] == basc_pkg::CAL_RESET && cal_q[5] == basc_pkg::CAL_RESET)
    else $error("calibration reset wrong");
endmodule : basc_top

// ==== basc_pkg.sv ====
// basc_pkg: shared constants and carrier types for the bridge adc serial/sleep control
// assumes a 25 MHz core clock standing in for the master clock
package basc_pkg;
  // serial word layout
  localparam int WORD_BITS      = 24;
  localparam int CMD_BITS       = 8;
  localparam int DATA_BITS      = 20;
  localparam int FLAG_BITS      = 4;
  // command byte: bit 7 set = write, low nibble = register select
  localparam int CMD_WR_POS     = 7;
  localparam logic [3:0] SEL_CONV  = 4'h0;
  localparam logic [3:0] SEL_CFG   = 4'h1;
  localparam logic [3:0] SEL_GAIN  = 4'h2;
  localparam logic [3:0] SEL_DAC   = 4'h3;
  localparam logic [3:0] SEL_ROFS  = 4'h4;
  localparam logic [3:0] SEL_NOFS  = 4'h5;
  // configuration word fields
  localparam int CFG_SLEEP_POS  = 0;
  localparam int CFG_FRST_POS   = 1;
  localparam logic [23:0] CFG_RESET = 24'h000000;
  localparam logic [23:0] CAL_RESET = 24'h000000;
  // output word period in master clock cycles
  localparam int WORD_PERIOD    = 81920;
  localparam int SETTLE_WORDS   = 6;

  typedef enum logic [1:0] {
    BASC_CMD  = 2'b00,
    BASC_WR   = 2'b01,
    BASC_RD   = 2'b11
  } basc_port_t;

  typedef struct packed {
    logic [WORD_BITS-1:0] word;
    logic [3:0]           sel;
    logic                 wr;
  } basc_xfer_t;

  typedef struct packed {
    logic frst;
    logic sleep;
  } basc_cfg_t;
endpackage : basc_pkg

// ==== basc_host.sv ====
// basc_host: behavioural host on the serial port of basc_top
// assumes input sampled on serial clock rise, output moved on fall
`timescale 1ns/1ns
module basc_host (
  output logic      sclk,   // serial clock, still between frames except for the reset flush pulses
  output logic      cs_n,   // chip select, active low
  output logic      serial_in_line,    // data to the device
  input  wire logic serial_out_line,    // data from the device
  input  wire logic sod_oe  // device drives sod
);
  logic [31:0] rx;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in_line  = 1'b0;
  end
  ////////////////////////////////////////
  // one frame, 8 command then 24 word bits msb first; sel low keeps the port deselected except in three-wire mode
  task automatic frame(input logic sel, input logic [7:0] cmd, input logic [23:0] wd,
                       output logic [23:0] rd);
    logic [31:0] tx;
    tx   = {cmd, wd};
    cs_n = ~sel;
    for (int i = 31; i >= 0; i--) begin
      serial_in_line = tx[i];
      #7 sclk = 1'b1;
      rx[i] = sod_oe ? serial_out_line : 1'bx; // undriven line never passes as data
      #8 sclk = 1'b0;
    end
    #8 cs_n = 1'b1;
    serial_in_line = ~tx[0]; // released line shows inverse, not last bit
    rd  = rx[23:0];
    #8; // gap so a following frame selects on a fresh time step
  endtask : frame
  // deselected clocks, needed to flush reset through the link domain
  task automatic pulses(input int n);
    cs_n = 1'b1;
    repeat (n) begin
      #7 sclk = 1'b1;
      #8 sclk = 1'b0;
    end
  endtask : pulses
endmodule : basc_host

// ==== basc_top_test.sv ====
// basc_top_test: directed bench for basc_top with a host model
// assumes the shortened word period below; host runs a 15 ns serial clock
`timescale 1ns/1ns
module basc_top_test;
  localparam int PER = 64; // short word period keeps the run brief
  logic        clk   = 1'b0;
  logic        rst_b = 1'b0;
  logic        mode  = 1'b0;
  logic [19:0] conv  = 20'hA5C3E;
  logic        ovr   = 1'b0;
  logic        busy  = 1'b0;
  logic        sclk, cs_n, serial_in_line, serial_out_line, sod_oe, rdy_n, sleep, frst;
  logic [23:0] rd;
  int          num_errors   = 0;
  int          total_checks = 0;
  int          n;
  always #20 clk = ~clk;
  basc_top #(.WORD_PERIOD(PER)) dut_u (.CLOCK(clk), .RST_B(rst_b), .SCLK(sclk), .CS_N(cs_n),
    .SERIAL_IN_LINE(serial_in_line), .WIRING_MODE_SELECT(mode), .CONV_RESULT(conv), .OVERRANGE(ovr),
    .CAL_BUSY(busy), .SERIAL_OUT_LINE(serial_out_line), .SERIAL_OUT_OE(sod_oe), .DATA_READY_N(rdy_n),
    .SLEEP(sleep), .FILTER_RESET_BIT(frst));
  basc_host host_u (.sclk(sclk), .cs_n(cs_n), .serial_in_line(serial_in_line), .serial_out_line(serial_out_line), .sod_oe(sod_oe));
  ////////////////////////////////////////
  // helpers
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  // cycles until the next falling data ready, bounded
  task automatic wait_rdy(output int k);
    k = 0;
    while (rdy_n !== 1'b1 && k < 400) begin cyc(1); k++; end
    while (rdy_n !== 1'b0 && k < 400) begin cyc(1); k++; end
  endtask : wait_rdy
  task automatic lows(input int k, output int c);
    c = 0;
    repeat (k) begin cyc(1); if (rdy_n !== 1'b1) c++; end
  endtask : lows
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  ////////////////////////////////////////
  // scenarios
  task automatic t_conv;
    chk("reset ready", 1, rdy_n);
    chk("reset sleep", 0, sleep);
    chk("idle oe", 0, sod_oe);
    wait_rdy(n);
    wait_rdy(n);
    chk("period", PER, n);
    host_u.frame(1'b1, 8'h00, 24'h0, rd);
    chk("conv word", {conv, 4'h0}, rd);
    cyc(4);
    chk("ready after read", 1, rdy_n);
    chk("oe after frame", 0, sod_oe);
    @(posedge clk) ovr <= 1'b1;
    wait_rdy(n);
    wait_rdy(n);
    host_u.frame(1'b1, 8'h00, 24'h0, rd);
    chk("overrange word", {conv, 4'hF}, rd);
    @(posedge clk) ovr <= 1'b0;
    $display("test conv done");
  endtask : t_conv
  task automatic t_cal;
    host_u.frame(1'b1, 8'h82, 24'h123456, rd);
    host_u.frame(1'b0, 8'h82, 24'h654321, rd); // deselected, must be ignored
    host_u.frame(1'b1, 8'h02, 24'h0, rd);
    chk("cal readback", 24'h123456, rd);
    @(posedge clk) mode <= 1'b1;
    cyc(2);
    host_u.frame(1'b0, 8'h02, 24'h0, rd);
    chk("three wire read", 24'h123456, rd);
    chk("three wire oe", 1, sod_oe);
    @(posedge clk) mode <= 1'b0;
    @(posedge clk) rst_b <= 1'b0;
    host_u.pulses(6);
    @(posedge clk) rst_b <= 1'b1;
    host_u.pulses(3);
    cyc(4);
    host_u.frame(1'b1, 8'h02, 24'h0, rd);
    chk("cal after reset", 24'h0, rd);
    $display("test cal done");
  endtask : t_cal
  task automatic t_sleep;
    wait_rdy(n);
    @(posedge clk) busy <= 1'b1;
    cyc(3);
    chk("ready in cal", 1, rdy_n);
    @(posedge clk) busy <= 1'b0;
    host_u.frame(1'b1, 8'h81, 24'h000001, rd);
    cyc(4);
    chk("asleep", 1, sleep);
    lows(2 * PER, n);
    chk("lows asleep", 0, n);
    host_u.frame(1'b1, 8'h81, 24'h000002, rd);
    cyc(4);
    chk("awake", 0, sleep);
    chk("filter held", 1, frst);
    lows(2 * PER, n);
    chk("lows held", 0, n);
    host_u.frame(1'b1, 8'h81, 24'h000000, rd);
    cyc(4);
    chk("filter free", 0, frst);
    wait_rdy(n);
    chk("resume", 1, n >= PER - 8 && n <= PER + 8);
    repeat (6) wait_rdy(n);
    host_u.frame(1'b1, 8'h00, 24'h0, rd);
    chk("settled word", {conv, 4'h0}, rd);
    $display("test sleep done");
  endtask : t_sleep
  ////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    fork
      host_u.pulses(8);
      repeat (12) @(posedge clk);
    join
    rst_b <= 1'b1;
    host_u.pulses(3);
    cyc(3);
    t_conv();
    t_cal();
    t_sleep();
    close_out();
  end
  initial begin
    #500000;
    num_errors++;
    close_out();
  end
endmodule : basc_top_test
